// >>> design/pai_alert_top.sv
// Functional notes
// (RULE1) Interrupt output low when any set flag has its enable bit high.
// (RULE2) Interrupt stays low until all pending enabled flags are cleared by one-writes.
// (RULE3) Interrupt released high once no flag is both set and enabled.
// (RULE4) Disabled events still set their flag but do not pull interrupt.
// (RULE5) High bit 7 sets when any enabled vendor source is set.
// (RULE6) Host clears vendor status before clearing the vendor summary flag.
// (RULE7) High bit 3 sets on sink-disconnect threshold crossing; zero after clear.
// (RULE8) High bit 2 sets on receive overflow; one-write acknowledges it.
// (RULE9) Overflow condition clears only by writing the receive-message flag.
// (RULE10) High bit 1 sets on any fault; fault detail lives elsewhere.
// (RULE11) High bit 0 sets on low-voltage alarm; zero after clear.
// (RULE12) Low enable byte: one enable per low flag, 1 unmasks.
// (RULE13) Enable high bit 7 gates the vendor summary onto the interrupt.
// (RULE14) Enable high bits 3:0 per flag; bits 6:4 read-only zero.
// (RULE15) Low byte flags 7..0: hi alarm, tx ok, discard, fail, hard reset, rx, power, cc.
// (RULE16) Zero-writes leave flags; set in same cycle as clear wins.
`timescale 1ns/1ps
`default_nettype none
module pai_alert_top (
    input wire logic clk_i,              // System clock, 250 MHz
    input wire logic sys_rst_i,          // Synchronous reset, active high
    input wire logic [7:0] reg_addr_i,   // Register address
    input wire logic reg_wr_i,           // Write strobe, one cycle
    input wire logic [7:0] reg_wdata_i,  // Write data
    input wire logic reg_rd_i,           // Read strobe, one cycle
    output logic [7:0] reg_rdata_o,      // Read data, one cycle after strobe
    input wire logic [7:0] low_event_i,  // Low byte event pulses
    input wire logic vendor_pending_i,   // Any enabled vendor source set, level
    input wire logic sink_disconnect_i,  // Threshold crossing pulse
    input wire logic rx_overflow_i,      // Receive buffer overflow pulse
    input wire logic fault_i,            // Any fault pulse
    input wire logic low_voltage_alarm_i, // Low-voltage alarm pulse
    output logic rx_overflow_pending_o,  // Overflow condition still held
    output logic [7:0] power_event_enable_o, // Power event enables
    output logic alert_n_o               // Interrupt, active low
);
    typedef struct packed {
        logic [7:0] enable_low;
        logic [7:0] enable_high;
        logic [7:0] power_enable;
        logic rx_overflow_pending;
        logic [7:0] rdata;
        logic alert_n;
    } pai_top_state_type;

    pai_top_state_type st;
    pai_top_state_type next_st;
    pai_flag_if low_if ();
    pai_flag_if high_if ();
    logic [7:0] high_events;
    logic any_pending;

    pai_flag_byte u_low (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .bus(low_if.owner)
    );
    pai_flag_byte u_high (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .bus(high_if.owner)
    );

    ////////////////////////////////////////////////////////////////////////
    // Events; the low byte carries its own sources in fixed order
    assign low_if.set = low_event_i; // RULE15 RULE4
    always_comb begin
        high_events = 8'h00;
        high_events[pai_pkg::VENDOR_BIT] = vendor_pending_i; // RULE5
        high_events[pai_pkg::SINK_DISCONNECT_BIT] = sink_disconnect_i; // RULE7
        high_events[pai_pkg::RX_OVERFLOW_BIT] = rx_overflow_i; // RULE8
        high_events[pai_pkg::FAULT_BIT] = fault_i; // RULE10
        high_events[pai_pkg::LOW_VOLTAGE_ALARM_BIT] = low_voltage_alarm_i; // RULE11
    end
    assign high_if.set = high_events;

    // Write-one-to-clear; zero bits untouched
    assign low_if.clear = (reg_wr_i && reg_addr_i == pai_pkg::ADDR_STATUS_LOW)
        ? reg_wdata_i : 8'h00; // RULE16
    assign high_if.clear = (reg_wr_i && reg_addr_i == pai_pkg::ADDR_STATUS_HIGH)
        ? (reg_wdata_i & pai_pkg::HIGH_WRITABLE) : 8'h00; // RULE8 RULE11 RULE7

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                pai_pkg::ADDR_ENABLE_LOW: next_st.enable_low = reg_wdata_i; // RULE12
                pai_pkg::ADDR_ENABLE_HIGH:
                    next_st.enable_high = reg_wdata_i & pai_pkg::HIGH_WRITABLE; // RULE14
                pai_pkg::ADDR_POWER_ENABLE: next_st.power_enable = reg_wdata_i;
                default: ;
            endcase
        end
        // Acknowledge alone keeps the condition; only the rx-message clear ends it
        if (rx_overflow_i) begin
            next_st.rx_overflow_pending = 1'b1;
        end else if (low_if.clear[pai_pkg::RX_MESSAGE_BIT]) begin
            next_st.rx_overflow_pending = 1'b0; // RULE9
        end
        next_st.rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                pai_pkg::ADDR_STATUS_LOW: next_st.rdata = low_if.flag;
                pai_pkg::ADDR_STATUS_HIGH: next_st.rdata = high_if.flag;
                pai_pkg::ADDR_ENABLE_LOW: next_st.rdata = st.enable_low;
                pai_pkg::ADDR_ENABLE_HIGH: next_st.rdata = st.enable_high;
                pai_pkg::ADDR_POWER_ENABLE: next_st.rdata = st.power_enable;
                default: next_st.rdata = 8'h00;
            endcase
        end
        // Next enables, so a mask write acts on the edge after it; a vendor source
        // still pending re-sets bit 7, so the host clears that source first
        any_pending = |(low_if.flag & next_st.enable_low)
            | |(high_if.flag & next_st.enable_high); // RULE1 RULE13
        // Looks at flags one cycle old, so interrupt trails the flag by a cycle
        next_st.alert_n = ~any_pending; // RULE2 RULE3
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= '{enable_low: pai_pkg::RST_ENABLE_LOW,
                    enable_high: pai_pkg::RST_ENABLE_HIGH,
                    power_enable: pai_pkg::RST_POWER_ENABLE,
                    rx_overflow_pending: 1'b0,
                    rdata: 8'h00,
                    alert_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign rx_overflow_pending_o = st.rx_overflow_pending;
    assign power_event_enable_o = st.power_enable;
    assign alert_n_o = st.alert_n;

    ////////////////////////////////////////////////////////////////////////
    // A mask write in the same cycle may release the line legally
    sequence s_no_low_enable_write;
        !(reg_wr_i && reg_addr_i == pai_pkg::ADDR_ENABLE_LOW);
    endsequence
    sequence s_no_high_enable_write;
        !(reg_wr_i && reg_addr_i == pai_pkg::ADDR_ENABLE_HIGH);
    endsequence
    sequence s_low_set_enabled;
        |(low_if.flag & st.enable_low);
    endsequence
    sequence s_vendor_only;
        high_if.flag == 8'h80 && low_if.flag == 8'h00;
    endsequence
    property p_assert_low;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_low_set_enabled ##0 s_no_low_enable_write |=> !alert_n_o;
    endproperty
    a_assert_low: assert property (p_assert_low) else $error("Interrupt not low"); // RULE1
    property p_hold_low;
        @(posedge clk_i) disable iff (sys_rst_i)
        (!alert_n_o && $past(any_pending) && any_pending) |=> !alert_n_o;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("Interrupt dropped early"); // RULE2
    property p_release;
        @(posedge clk_i) disable iff (sys_rst_i)
        !any_pending |=> alert_n_o;
    endproperty
    a_release: assert property (p_release) else $error("Interrupt not released"); // RULE3
    property p_masked_records;
        @(posedge clk_i) disable iff (sys_rst_i)
        (low_event_i != 8'h00 && st.enable_low == 8'h00 && st.enable_high == 8'h00)
        |=> (low_if.flag != 8'h00) ##1 alert_n_o;
    endproperty
    a_masked_records: assert property (p_masked_records) else $error("Masked event"); // RULE4
    property p_vendor_sets;
        @(posedge clk_i) disable iff (sys_rst_i)
        vendor_pending_i |=> high_if.flag[pai_pkg::VENDOR_BIT];
    endproperty
    a_vendor_sets: assert property (p_vendor_sets) else $error("Vendor flag missing"); // RULE5
    property p_ovf_kept;
        @(posedge clk_i) disable iff (sys_rst_i)
        (st.rx_overflow_pending && !low_if.clear[pai_pkg::RX_MESSAGE_BIT])
        |=> rx_overflow_pending_o;
    endproperty
    a_ovf_kept: assert property (p_ovf_kept) else $error("Overflow cleared by ack"); // RULE9
    property p_reserved_zero;
        @(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |-> (st.enable_high[6:4] == 3'b000 && high_if.flag[6:4] == 3'b000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set"); // RULE14
    property p_enable_write;
        @(posedge clk_i) disable iff (sys_rst_i)
        (reg_wr_i && reg_addr_i == pai_pkg::ADDR_ENABLE_LOW)
        |=> st.enable_low == $past(reg_wdata_i);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("Enable not written"); // RULE12
    property p_low_masked;
        @(posedge clk_i) disable iff (sys_rst_i)
        ((low_if.flag & st.enable_low) == 8'h00 && high_if.flag == 8'h00)
        ##0 s_no_low_enable_write |=> alert_n_o;
    endproperty
    a_low_masked: assert property (p_low_masked) else $error("Masked flag pulled line"); // RULE12
    property p_vendor_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_vendor_only ##0 s_no_high_enable_write ##0 !st.enable_high[pai_pkg::VENDOR_BIT]
        |=> alert_n_o;
    endproperty
    a_vendor_gate: assert property (p_vendor_gate) else $error("Vendor not gated"); // RULE13
    property p_sink_sets;
        @(posedge clk_i) disable iff (sys_rst_i)
        sink_disconnect_i |=> high_if.flag[pai_pkg::SINK_DISCONNECT_BIT];
    endproperty
    a_sink_sets: assert property (p_sink_sets) else $error("Sink flag missing"); // RULE7
    property p_ovf_sets;
        @(posedge clk_i) disable iff (sys_rst_i)
        rx_overflow_i |=> high_if.flag[pai_pkg::RX_OVERFLOW_BIT] && rx_overflow_pending_o;
    endproperty
    a_ovf_sets: assert property (p_ovf_sets) else $error("Overflow flag missing"); // RULE8
    property p_fault_sets;
        @(posedge clk_i) disable iff (sys_rst_i)
        fault_i |=> high_if.flag[pai_pkg::FAULT_BIT];
    endproperty
    a_fault_sets: assert property (p_fault_sets) else $error("Fault flag missing"); // RULE10
    property p_alarm_clears;
        @(posedge clk_i) disable iff (sys_rst_i)
        (high_if.clear[pai_pkg::LOW_VOLTAGE_ALARM_BIT] && !low_voltage_alarm_i)
        |=> !high_if.flag[pai_pkg::LOW_VOLTAGE_ALARM_BIT];
    endproperty
    a_alarm_clears: assert property (p_alarm_clears) else $error("Alarm not cleared"); // RULE11
endmodule : pai_alert_top
`default_nettype wire

// >>> design/pai_pkg.sv
package pai_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_STATUS_LOW = 8'h10;
    localparam logic [7:0] ADDR_STATUS_HIGH = 8'h11;
    localparam logic [7:0] ADDR_ENABLE_LOW = 8'h12;
    localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h13;
    localparam logic [7:0] ADDR_POWER_ENABLE = 8'h14;
    // Reset values
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_ENABLE_LOW = 8'hff;
    localparam logic [7:0] RST_ENABLE_HIGH = 8'h0f;
    localparam logic [7:0] RST_POWER_ENABLE = 8'hff;
    // Field positions, high status and enable bytes
    localparam int VENDOR_BIT = 7;
    localparam int SINK_DISCONNECT_BIT = 3;
    localparam int RX_OVERFLOW_BIT = 2;
    localparam int FAULT_BIT = 1;
    localparam int LOW_VOLTAGE_ALARM_BIT = 0;
    // Field position, low status byte
    localparam int RX_MESSAGE_BIT = 2;
    // Writable bits of the high bytes; 6:4 reserved
    localparam logic [7:0] HIGH_WRITABLE = 8'h8f;
endpackage : pai_pkg

// >>> design/pai_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pai_flag_if;
    logic [7:0] set;
    logic [7:0] clear;
    logic [7:0] flag;
    modport owner (input set, input clear, output flag);
    modport user (output set, output clear, input flag);
endinterface : pai_flag_if
`default_nettype wire

// >>> design/pai_flag_byte.sv
`timescale 1ns/1ps
`default_nettype none
module pai_flag_byte (
    input wire logic clk_i,        // System clock
    input wire logic sys_rst_i,    // Synchronous reset, active high
    pai_flag_if.owner bus          // Set, clear and flag byte
);
    typedef struct packed {
        logic [7:0] flag;
    } pai_flag_state_type;

    pai_flag_state_type st;
    pai_flag_state_type next_st;

    // Set wins over clear in the same cycle
    always_comb begin
        next_st = st;
        next_st.flag = (st.flag & ~bus.clear) | bus.set; // RULE16
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= '{flag: pai_pkg::RST_STATUS};
        end else begin
            st <= next_st;
        end
    end

    assign bus.flag = st.flag;

    ////////////////////////////////////////////////////////////////////////
    property p_set_wins;
        @(posedge clk_i) disable iff (sys_rst_i)
        (bus.set != 8'h00) |=> ((bus.flag & $past(bus.set)) == $past(bus.set));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Flag set lost"); // RULE16
    property p_zero_keeps;
        @(posedge clk_i) disable iff (sys_rst_i)
        (bus.clear == 8'h00 && bus.set == 8'h00) |=> $stable(bus.flag);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("Flag changed"); // RULE16
endmodule : pai_flag_byte
`default_nettype wire

// >>> sim/pai_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pai_host_model (
    input wire logic clk_i,         // System clock
    input wire logic [7:0] rdata_i, // Read data from the device
    output logic [7:0] addr_o,      // Register address
    output logic wr_o,              // Write strobe
    output logic [7:0] wdata_o,     // Write data
    output logic rd_o               // Read strobe
);
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    // Strobes last one edge; the next call waits an edge, so no double drive
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask : rd
endmodule : pai_host_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] low_event_i = 8'h00;
    logic vendor_pending_i = 1'b0;
    logic [3:0] hi_ev = 4'h0;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, power_event_enable_o, d, ev, en;
    logic reg_wr_i, reg_rd_i, rx_overflow_pending_o, alert_n_o;
    logic [7:0] radr [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
    logic [7:0] rval [6] = '{8'h00, 8'h00, 8'hff, 8'h0f, 8'hff, 8'h00};
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    pai_host_model host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .wr_o(reg_wr_i), .wdata_o(reg_wdata_i), .rd_o(reg_rd_i));
    pai_alert_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .low_event_i(low_event_i),
        .vendor_pending_i(vendor_pending_i), .sink_disconnect_i(hi_ev[3]),
        .rx_overflow_i(hi_ev[2]), .fault_i(hi_ev[1]), .low_voltage_alarm_i(hi_ev[0]),
        .rx_overflow_pending_o(rx_overflow_pending_o),
        .power_event_enable_o(power_event_enable_o), .alert_n_o(alert_n_o));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Whole run needs about 370 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            give_verdict();
        end
    end
    function automatic logic exp_alert(input logic [7:0] s, input logic [7:0] m);
        return ~|(s & m);
    endfunction : exp_alert
    task automatic pulse(input logic [3:0] h, input logic [7:0] l);
        @(posedge clk_i);
        hi_ev <= h;
        low_event_i <= l;
        @(posedge clk_i);
        hi_ev <= 4'h0;
        low_event_i <= 8'h00;
    endtask : pulse
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h1112));
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            host.rd(radr[i], d);
            `CHK("reset_value", rval[i], d)
        end
        $display("test reset done");
        for (int b = 0; b < 4; b++) begin
            pulse(4'(1 << b), 8'h00);
            settle();
            host.rd(8'h11, d);
            `CHK("hi_flag", 8'(1 << b), d)
            `CHK("alert_low", 1'b0, alert_n_o)
            host.wr(8'h11, 8'h00);
            settle();
            `CHK("alert_held", 1'b0, alert_n_o)
            host.wr(8'h11, 8'(1 << b));
            settle();
            `CHK("alert_free", 1'b1, alert_n_o)
            host.rd(8'h11, d);
            `CHK("hi_cleared", 8'h00, d)
            if (b == 2) begin
                `CHK("ovf_held", 1'b1, rx_overflow_pending_o)
                host.wr(8'h10, 8'h04);
                settle();
                `CHK("ovf_gone", 1'b0, rx_overflow_pending_o)
            end
        end
        $display("test high flags done");
        host.wr(8'h13, 8'hff);
        host.rd(8'h13, d);
        `CHK("enable_hi", 8'h8f, d)
        host.wr(8'h13, 8'h00);
        pulse(4'b0010, 8'h00);
        settle();
        host.rd(8'h11, d);
        `CHK("masked_flag", 8'h02, d)
        `CHK("masked_alert", 1'b1, alert_n_o)
        host.wr(8'h13, 8'h02);
        settle();
        `CHK("unmask_alert", 1'b0, alert_n_o)
        host.wr(8'h13, 8'h00);
        settle();
        `CHK("remask_alert", 1'b1, alert_n_o)
        host.wr(8'h11, 8'h02);
        host.wr(8'h13, 8'h0f);
        $display("test masking done");
        @(posedge clk_i);
        vendor_pending_i <= 1'b1;
        settle();
        host.rd(8'h11, d);
        `CHK("vendor_flag", 8'h80, d)
        `CHK("vendor_gated", 1'b1, alert_n_o)
        host.wr(8'h13, 8'h8f);
        settle();
        `CHK("vendor_alert", 1'b0, alert_n_o)
        // Vendor source drops before the summary is cleared
        @(posedge clk_i);
        vendor_pending_i <= 1'b0;
        host.wr(8'h11, 8'h80);
        settle();
        host.rd(8'h11, d);
        `CHK("vendor_clear", 8'h00, d)
        `CHK("vendor_free", 1'b1, alert_n_o)
        $display("test vendor done");
        host.wr(8'h12, 8'h00);
        host.wr(8'h13, 8'h00);
        pulse(4'h0, 8'h5a);
        settle();
        host.rd(8'h10, d);
        `CHK("masked_lo", 8'h5a, d)
        `CHK("masked_lo_alert", 1'b1, alert_n_o)
        host.wr(8'h10, 8'hff);
        pulse(4'h1, 8'h00);
        // Event and its clear land on the same edge
        fork
            pulse(4'h1, 8'h00);
            host.wr(8'h11, 8'h01);
        join
        host.rd(8'h11, d);
        `CHK("set_wins", 8'h01, d)
        host.wr(8'h11, 8'h01);
        host.wr(8'h13, 8'h0f);
        $display("test corners done");
        for (int i = 0; i < 16; i++) begin
            ev = 8'($urandom());
            en = 8'($urandom());
            host.wr(8'h12, en);
            host.wr(8'h14, ~en);
            pulse(4'h0, ev);
            settle();
            host.rd(8'h10, d);
            `CHK("lo_flags", ev, d)
            `CHK("lo_alert", exp_alert(ev, en), alert_n_o)
            `CHK("power_enable", ~en, power_event_enable_o)
            host.wr(8'h10, 8'hff);
            settle();
            `CHK("lo_free", 1'b1, alert_n_o)
        end
        $display("test random low flags done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
